/* File: verilog/pcrm_host.sv */
// Host end: AXI4-Lite slave taking software commands and running one
// byte access at a time over the register link.
// Assumes the device acks each request and that software keeps the
// page procedure: select a page, then touch only valid locations.
`timescale 1ns/100ps
`default_nettype none
module pcrm_host (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Register link
    pcrm_link_if.host link,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import pcrm_pkg::*;

    // ------------------------------------------------------------
    // Write channel capture
    // ------------------------------------------------------------
    logic aw_full_q;
    logic w_full_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic do_write;
    pcrm_state_t state_q;
    logic done_q;
    logic [7:0] rdbyte_q;
    logic req_q;
    logic we_q;
    logic [7:0] addr_q;
    logic [7:0] wbyte_q;
    logic cmd_ok;

    // Address and data are taken in either order, one of each at a time
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (do_write) begin
                aw_full_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (do_write) begin
                w_full_q <= 1'b0;
            end
        end
    end

    assign do_write = aw_full_q && w_full_q && !bvalid_q;
    // A command needs the two low lanes; refused while a link access runs
    assign cmd_ok = awaddr_q == HOST_CMD && state_q == PCRM_IDLE && wstrb_q[1:0] == 2'b11;

    // Response: a taken command is OKAY, a status write is accepted and ignored, others are errors
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= (cmd_ok || awaddr_q == HOST_STATUS) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_awready = !aw_full_q;
    assign s_axi_wready = !w_full_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // ------------------------------------------------------------
    // Link sequencer
    // ------------------------------------------------------------
    // Request is held until the device acks, then dropped at once
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_q <= PCRM_IDLE;
            req_q <= 1'b0;
            we_q <= 1'b0;
            addr_q <= 8'h00;
            wbyte_q <= 8'h00;
            rdbyte_q <= 8'h00;
        end else begin
            case (state_q)
                PCRM_IDLE: begin
                    if (do_write && cmd_ok) begin
                        state_q <= PCRM_REQ;
                        req_q <= 1'b1;
                        we_q <= wdata_q[CMD_WRITE_BIT];
                        addr_q <= {1'b0, wdata_q[CMD_OFF_LSB +: OFF_W]};
                        wbyte_q <= wdata_q[7:0];
                    end
                end
                PCRM_REQ: begin
                    if (link.ack) begin
                        state_q <= PCRM_DONE;
                        req_q <= 1'b0;
                        rdbyte_q <= link.rdata;
                    end
                end
                PCRM_DONE: begin
                    state_q <= PCRM_IDLE;
                end
                default: begin
                    state_q <= PCRM_IDLE;
                    req_q <= 1'b0;
                end
            endcase
        end
    end

    // Done is sticky until the next command; completion wins the same cycle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            done_q <= 1'b0;
        end else if (state_q == PCRM_REQ && link.ack) begin
            done_q <= 1'b1;
        end else if (do_write && cmd_ok) begin
            done_q <= 1'b0;
        end
    end

    assign link.req = req_q;
    assign link.we = we_q;
    assign link.addr = addr_q;
    assign link.wdata = wbyte_q;

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // One read at a time; arready falls while the answer is pending
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0000_0000;
            if (s_axi_araddr == HOST_STATUS) begin
                rdata_q[STS_BUSY_BIT] <= state_q != PCRM_IDLE;
                rdata_q[STS_DONE_BIT] <= done_q;
                rdata_q[STS_RDATA_LSB +: 8] <= rdbyte_q;
            end else if (s_axi_araddr == HOST_CMD) begin
                rdata_q[CMD_WRITE_BIT] <= we_q;
                // Offset field only, so the write flag in bit 15 survives
                rdata_q[CMD_OFF_LSB +: OFF_W] <= addr_q[OFF_W-1:0];
                rdata_q[7:0] <= wbyte_q;
            end else begin
                rresp_q <= RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule
`default_nettype wire

/* File: inc/pcrm_pkg.sv */
// Package for the paged control register map: link widths, page 0 map,
// reset values and field masks. Shared by both ends and by the interface.
package pcrm_pkg;

    // ------------------------------------------------------------
    // Link and page geometry
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int OFF_W = 7;
    localparam int PAGE_SIZE = 128;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [7:0] PAGE_CONFIG = 8'h00;
    localparam logic [7:0] PAGE_COEF_FIRST = 8'h02;
    localparam logic [7:0] PAGE_COEF_LAST = 8'h04;
    localparam int COEF_PAGES = 3;

    // ------------------------------------------------------------
    // Page 0 offsets that the logic treats specially
    // ------------------------------------------------------------
    localparam logic [6:0] OFF_BANK_SELECT = 7'h00;
    localparam logic [6:0] OFF_SOFT_RESTART = 7'h01;
    localparam logic [6:0] OFF_LOW_POWER = 7'h02;
    localparam logic [6:0] OFF_POWER_DOWN = 7'h05;
    localparam logic [6:0] OFF_BUS_CLOCK_MONITOR = 7'h15;
    localparam logic [6:0] OFF_GENERAL_PIN_MONITOR = 7'h2a;
    localparam logic [6:0] OFF_INPUT_PIN_MONITOR = 7'h2f;
    localparam logic [6:0] OFF_IRQ_MASK = 7'h33;
    localparam logic [6:0] OFF_IRQ_LATCHED = 7'h36;
    localparam int SOFT_RESTART_BIT = 0;

    // ------------------------------------------------------------
    // Host command port (AXI4-Lite byte addresses) and fields
    // ------------------------------------------------------------
    localparam logic [7:0] HOST_CMD = 8'h00;
    localparam logic [7:0] HOST_STATUS = 8'h04;
    localparam int CMD_WRITE_BIT = 15;
    localparam int CMD_OFF_LSB = 8;
    localparam int STS_BUSY_BIT = 0;
    localparam int STS_DONE_BIT = 1;
    localparam int STS_RDATA_LSB = 8;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Host link sequencer states
    typedef enum logic [2:0] {
        PCRM_IDLE = 3'b001,
        PCRM_REQ = 3'b010,
        PCRM_DONE = 3'b100
    } pcrm_state_t;

    // Reset value of each page 0 location; 0 for reserved ones
    function automatic logic [7:0] p0_reset(input logic [6:0] off);
        case (off)
            7'h05: p0_reset = 8'h05;
            7'h07: p0_reset = 8'h30;
            7'h0c: p0_reset = 8'h01;
            7'h0d: p0_reset = 8'h02;
            7'h0e: p0_reset = 8'h03;
            7'h13: p0_reset = 8'h02;
            7'h14: p0_reset = 8'h48;
            7'h15: p0_reset = 8'hff;
            7'h16: p0_reset = 8'h10;
            7'h1f: p0_reset = 8'h40;
            7'h21: p0_reset = 8'h22;
            7'h33: p0_reset = 8'hff;
            7'h3e, 7'h43, 7'h48, 7'h4d: p0_reset = 8'hc9;
            7'h3f, 7'h44, 7'h49, 7'h4e: p0_reset = 8'h80;
            7'h6b: p0_reset = 8'h01;
            7'h6c: p0_reset = 8'h40;
            7'h6d: p0_reset = 8'h7b;
            default: p0_reset = 8'h00;
        endcase
    endfunction

    // Locations present in page 0
    function automatic logic p0_valid(input logic [6:0] off);
        case (off)
            7'h00, 7'h01, 7'h02, 7'h05, 7'h07, 7'h08, 7'h09, 7'h0a, 7'h0b,
            7'h0c, 7'h0d, 7'h0e, 7'h13, 7'h14, 7'h15, 7'h16, 7'h1f, 7'h20,
            7'h21, 7'h22, 7'h29, 7'h2a, 7'h2b, 7'h2f, 7'h32, 7'h33, 7'h36,
            7'h3a, 7'h3b, 7'h3c, 7'h3d, 7'h3e, 7'h3f, 7'h40, 7'h41, 7'h42,
            7'h43, 7'h44, 7'h45, 7'h48, 7'h49, 7'h4a, 7'h4d, 7'h4e,
            7'h4f, 7'h6b, 7'h6c, 7'h6d: p0_valid = 1'b1;
            default: p0_valid = 1'b0;
        endcase
    endfunction

    // Bits a write may change; read-only bits and status registers excluded
    function automatic logic [7:0] p0_wmask(input logic [6:0] off);
        case (off)
            7'h01: p0_wmask = 8'h00;
            7'h02: p0_wmask = 8'hfd;
            7'h05: p0_wmask = 8'h3f;
            7'h15, 7'h2a, 7'h2f, 7'h36: p0_wmask = 8'h00;
            default: p0_wmask = p0_valid(off) ? 8'hff : 8'h00;
        endcase
    endfunction

endpackage

/* File: inc/pcrm_link_if.sv */
// Interface joining the host end and the device end of the register link.
// Assumes both ends run on the same clock, which the bench supplies.
`timescale 1ns/100ps
`default_nettype none
interface pcrm_link_if;
    import pcrm_pkg::*;
    // Request group, driven by the host
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    // Answer group, driven by the device
    logic ack;
    logic [7:0] rdata;

    modport dev (input req, input we, input addr, input wdata, output ack, output rdata);
    modport host (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface
`default_nettype wire

/* File: verilog/pcrm_device.sv */
// Device end: paged byte register bank behind the register link.
// Assumes the link partner is clocked by mclk and holds a request until ack.
// Status inputs come from logic on mclk and need no synchroniser.
`timescale 1ns/100ps
`default_nettype none
module pcrm_device #(
    parameter logic [7:0] COEF_RESET = 8'h00
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Register link
    pcrm_link_if.dev link,
    // Status sources for the read-only locations
    input wire logic [pcrm_pkg::DATA_W-1:0] bus_clock_status,
    input wire logic [pcrm_pkg::DATA_W-1:0] general_pin_status,
    input wire logic [pcrm_pkg::DATA_W-1:0] input_pin_status,
    input wire logic [pcrm_pkg::DATA_W-1:0] irq_latched_status,
    // Configuration seen by the rest of the converter
    output logic [pcrm_pkg::DATA_W-1:0] cur_page,
    output logic soft_restart_pulse,
    output logic [pcrm_pkg::DATA_W-1:0] low_power_cfg,
    output logic [pcrm_pkg::DATA_W-1:0] power_down_cfg,
    output logic [pcrm_pkg::DATA_W-1:0] irq_mask_cfg
);
    import pcrm_pkg::*;

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    logic ack_q;
    logic [7:0] rdata_q;
    logic [7:0] page_q;
    logic soft_q;
    logic take;
    logic wr;
    logic [6:0] off;
    logic in_coef;
    logic [1:0] coef_idx;
    logic [7:0] coef_sel;

    // A request is taken once; the ack cycle masks the still-high request
    assign take = link.req && !ack_q;
    assign wr = take && link.we;
    assign off = link.addr[OFF_W-1:0];
    // Offsets beyond 7 bits are not part of any page
    assign in_coef = (page_q >= PAGE_COEF_FIRST) && (page_q <= PAGE_COEF_LAST);
    assign coef_sel = page_q - PAGE_COEF_FIRST;
    assign coef_idx = coef_sel[1:0];

    // ------------------------------------------------------------
    // Page select and soft restart
    // ------------------------------------------------------------
    // Page switch works from any page; value is the page number itself
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            page_q <= PAGE_RESET;
        end else if (soft_q) begin
            page_q <= PAGE_RESET;
        end else if (wr && off == OFF_BANK_SELECT) begin
            page_q <= link.wdata;
        end
    end

    // One-cycle restart; the stored bit never sticks, so it reads as 0
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            soft_q <= 1'b0;
        end else begin
            soft_q <= wr && page_q == PAGE_CONFIG && off == OFF_SOFT_RESTART
                && link.wdata[SOFT_RESTART_BIT];
        end
    end

    // ------------------------------------------------------------
    // Page 0 configuration bytes
    // ------------------------------------------------------------
    logic [7:0] p0_q [PAGE_SIZE];

    genvar gi;
    generate
        for (gi = 1; gi < PAGE_SIZE; gi++) begin : g_p0
            localparam logic [6:0] OFF = 7'(gi);
            localparam logic [7:0] RST = p0_reset(OFF);
            localparam logic [7:0] MSK = p0_wmask(OFF);
            // Status locations follow their sources, others take masked writes
            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    p0_q[gi] <= RST;
                end else if (soft_q) begin
                    p0_q[gi] <= RST;
                end else if (OFF == OFF_BUS_CLOCK_MONITOR) begin
                    p0_q[gi] <= bus_clock_status;
                end else if (OFF == OFF_GENERAL_PIN_MONITOR) begin
                    p0_q[gi] <= general_pin_status;
                end else if (OFF == OFF_INPUT_PIN_MONITOR) begin
                    p0_q[gi] <= input_pin_status;
                end else if (OFF == OFF_IRQ_LATCHED) begin
                    p0_q[gi] <= irq_latched_status;
                end else if (wr && page_q == PAGE_CONFIG && off == OFF) begin
                    // Read-only bits keep their value whatever is written
                    p0_q[gi] <= (link.wdata & MSK) | (p0_q[gi] & ~MSK);
                end
            end
        end
    endgenerate
    assign p0_q[0] = 8'h00;

    // ------------------------------------------------------------
    // Coefficient pages
    // ------------------------------------------------------------
    logic [7:0] coef_q [COEF_PAGES][PAGE_SIZE];

    genvar gp, gc;
    generate
        for (gp = 0; gp < COEF_PAGES; gp++) begin : g_cp
            assign coef_q[gp][0] = 8'h00;
            for (gc = 1; gc < PAGE_SIZE; gc++) begin : g_cb
                // Every location but offset 0 of these pages is a full byte of coefficient
                always_ff @(posedge mclk or negedge nrst) begin
                    if (!nrst) begin
                        coef_q[gp][gc] <= COEF_RESET;
                    end else if (soft_q) begin
                        coef_q[gp][gc] <= COEF_RESET;
                    end else if (wr && in_coef && coef_idx == gp && off == gc) begin
                        coef_q[gp][gc] <= link.wdata;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Read path and answer
    // ------------------------------------------------------------
    logic [7:0] rd_d;

    // Reserved pages and locations read as 0; writes there are dropped
    always_comb begin
        rd_d = 8'h00;
        if (off == OFF_BANK_SELECT) begin
            rd_d = page_q;
        end else if (page_q == PAGE_CONFIG && p0_valid(off)) begin
            rd_d = p0_q[off];
        end else if (in_coef) begin
            rd_d = coef_q[coef_idx][off];
        end
    end

    // Ack one cycle after the request is taken, data with it
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ack_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            ack_q <= take;
            if (take) begin
                rdata_q <= rd_d;
            end
        end
    end

    assign link.ack = ack_q;
    assign link.rdata = rdata_q;
    assign cur_page = page_q;
    assign soft_restart_pulse = soft_q;
    assign low_power_cfg = p0_q[OFF_LOW_POWER];
    assign power_down_cfg = p0_q[OFF_POWER_DOWN];
    assign irq_mask_cfg = p0_q[OFF_IRQ_MASK];

endmodule
`default_nettype wire

/* File: tb/pcrm_link_properties.sv */
// Checker for the register link between host end and device end.
// Assumes one clock, mclk, and nrst active low.
`timescale 1ns/100ps
`default_nettype none
module pcrm_link_properties (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Link signals
    input wire logic req,
    input wire logic we,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic ack,
    input wire logic [7:0] rdata
);
    logic [7:0] page_q;
    logic fresh_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    // Page as the link has set it
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            page_q <= 8'h00;
        end else if (ack && we && addr == 8'h00) begin
            page_q <= wdata;
        end
    end

    // Mask untouched since reset; a restart makes it fresh again
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            fresh_q <= 1'b1;
        end else if (ack && we && page_q == 8'h00) begin
            fresh_q <= (addr == 8'h01 && wdata[0]) || (fresh_q && addr != 8'h33);
        end
    end

    sequence take_s;
        req && !ack;
    endsequence
    sequence answer_s;
        ack && req ##1 !ack && !req;
    endsequence

    link_walk_a: assert property (take_s |=> answer_s)
        else $error("link transfer walk broken");
    req_hold_a: assert property (take_s |=> $stable(addr) && $stable(we) && $stable(wdata))
        else $error("request changed before ack");
    ack_cause_a: assert property ($rose(ack) |-> $past(req) && !$past(ack))
        else $error("ack without request");
    req_gap_a: assert property ($fell(req) |=> !req)
        else $error("requests too close");
    offset_width_a: assert property (req |-> addr[7] == 1'b0)
        else $error("offset wider than seven bits");
    page_read_a: assert property (ack && !we && addr == 8'h00 |-> rdata == page_q)
        else $error("page select readback wrong");
    rdata_hold_a: assert property ($fell(ack) && !we |-> $stable(rdata))
        else $error("read byte not held");
    mask_reset_a: assert property (ack && !we && addr == 8'h33 && page_q == 8'h00 && fresh_q
        |-> rdata == 8'hff)
        else $error("mask not at reset value");
endmodule
`default_nettype wire

/* File: tb/paged_control_register_map_tb.sv */
// Bench: software side over AXI4-Lite, device outputs watched directly.
// Assumes the package and both ends compiled before it.
`timescale 1ns/100ps
`default_nettype none
module paged_control_register_map_tb;
    import pcrm_pkg::*;
    logic mclk, nrst, awvalid, wvalid, bready, arvalid, rready, pulse, pulse_seen;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr, clk_sts, pin_sts, gpi_sts, irq_sts, rd;
    logic [7:0] cur_page, lp_cfg, pd_cfg, mask_cfg;
    logic [31:0] wdat, rdat, rv;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    int miscompares = 0;
    int check_count = 0;
    // {page, offset, written, expected}
    // Reserved bits are written with their defaults; no reserved page or location
    logic [31:0] rows [15] = '{32'h00335a5a, 32'h00029d9d, 32'h00053535, 32'h00010000,
        32'h000c1111, 32'h006d0000, 32'h0210a5a5, 32'h037f3c3c, 32'h027fe1e1, 32'h0401c3c3,
        32'h03107777, 32'h04106666, 32'h0015006e, 32'h00360081, 32'h002f00a3};
    // {offset, reset value}
    logic [15:0] rst_tab [6] = '{16'h33ff, 16'h15ff, 16'h0505, 16'h3ec9, 16'h6d7b, 16'h0000};

    pcrm_link_if u_link ();
    pcrm_host u_pcrm_host (.mclk(mclk), .nrst(nrst), .link(u_link.host),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdat), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    pcrm_device u_pcrm_device (.mclk(mclk), .nrst(nrst), .link(u_link.dev),
        .bus_clock_status(clk_sts), .general_pin_status(pin_sts), .input_pin_status(gpi_sts),
        .irq_latched_status(irq_sts), .cur_page(cur_page), .soft_restart_pulse(pulse),
        .low_power_cfg(lp_cfg), .power_down_cfg(pd_cfg), .irq_mask_cfg(mask_cfg));
    pcrm_link_properties u_pcrm_link_properties (.mclk(mclk), .nrst(nrst), .req(u_link.req),
        .we(u_link.we), .addr(u_link.addr), .wdata(u_link.wdata), .ack(u_link.ack),
        .rdata(u_link.rdata));

    // Free-running clock, 10 ns
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Restart pulse is one cycle wide, so latch it
    always @(posedge mclk) begin
        if (pulse === 1'b1) pulse_seen <= 1'b1;
    end

    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk2(input string n, input logic [1:0] e, input logic [1:0] g);
        chk8(n, {6'h00, e}, {6'h00, g});
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One AXI write; response left in rs. With now set the write starts at
    // the edge that took the previous response; bready simply stays high
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        input bit now = 1'b0);
        if (!now) @(posedge mclk);
        awaddr <= a;
        wdat <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
    endtask

    // One AXI read; data in rv, response in rs
    task automatic axi_rd(input logic [7:0] a);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rv = rdat;
        rs = rresp;
        rready <= 1'b0;
    endtask

    // Poll status until the link transfer is done; only the watchdog ends a hang
    task automatic wait_idle();
        do begin
            axi_rd(HOST_STATUS);
        end while (rv[STS_DONE_BIT] !== 1'b1 || rv[STS_BUSY_BIT] !== 1'b0);
        rd = rv[STS_RDATA_LSB +: 8];
    endtask

    // One byte over the link; a read leaves its byte in rd
    task automatic op(input logic w, input logic [6:0] o, input logic [7:0] d);
        axi_wr(HOST_CMD, {16'h0000, w, o, d}, 4'h3);
        chk2("command response", RESP_OKAY, rs);
        wait_idle();
    endtask

    initial begin
        {awvalid, wvalid, bready, arvalid, rready, pulse_seen} = 6'h00;
        {awaddr, araddr, wdat, wstrb} = '0;
        {clk_sts, pin_sts, gpi_sts, irq_sts} = 32'hff5ca381;
        nrst = 1'b0;
        repeat (8) @(posedge mclk);
        chk8("mask during reset", 8'hff, mask_cfg);
        nrst <= 1'b1;
        foreach (rst_tab[i]) begin
            op(1'b0, rst_tab[i][14:8], 8'h00);
            chk8("reset value", rst_tab[i][7:0], rd);
        end
        chk8("reset page", 8'h00, cur_page);
        chk8("reset power", 8'h05, pd_cfg);
        clk_sts <= 8'h6e;
        foreach (rows[i]) begin
            op(1'b1, 7'h00, rows[i][31:24]);
            op(1'b1, rows[i][22:16], rows[i][15:8]);
            op(1'b0, rows[i][22:16], 8'h00);
            chk8("row byte", rows[i][7:0], rd);
            chk8("row page", rows[i][31:24], cur_page);
        end
        op(1'b1, 7'h00, 8'hff);
        chk8("top page", 8'hff, cur_page);
        op(1'b1, 7'h00, 8'h03);
        op(1'b0, 7'h7f, 8'h00);
        chk8("page isolation", 8'h3c, rd);
        // Refused AXI accesses, and an accepted status write
        axi_wr(8'h08, 32'h0, 4'hf);
        chk2("unmapped write", RESP_SLVERR, rs);
        axi_rd(8'h08);
        chk2("unmapped read", RESP_SLVERR, rs);
        axi_wr(HOST_CMD, 32'h0000b311, 4'h1);
        chk2("partial command", RESP_SLVERR, rs);
        axi_wr(HOST_STATUS, 32'h0, 4'hf);
        chk2("status write", RESP_OKAY, rs);
        // A command straight after the previous response meets a busy link:
        // refused, and it changes nothing
        op(1'b1, 7'h00, 8'h00);
        axi_wr(HOST_CMD, 32'h0000b311, 4'h3);
        axi_wr(HOST_CMD, 32'h0000b322, 4'h3, 1'b1);
        chk2("busy command", RESP_SLVERR, rs);
        wait_idle();
        chk8("mask output", 8'h11, mask_cfg);
        chk8("sleep output", 8'h9d, lp_cfg);
        axi_rd(HOST_CMD);
        chk8("command readback", 8'hb3, rv[15:8]);
        // Soft restart returns mask, restart bit and coefficients to reset
        op(1'b1, 7'h00, 8'h02);
        op(1'b1, 7'h10, 8'h5a);
        op(1'b1, 7'h00, 8'h00);
        op(1'b1, 7'h01, 8'h01);
        chk8("restart pulse", 8'h01, {7'h00, pulse_seen});
        chk8("restart mask", 8'hff, mask_cfg);
        op(1'b0, 7'h01, 8'h00);
        chk8("restart bit clears", 8'h00, rd);
        op(1'b1, 7'h00, 8'h02);
        op(1'b0, 7'h10, 8'h00);
        chk8("restart coefficient", 8'h00, rd);
        stop_test();
    end

    // Watchdog: the whole run needs under a thousand cycles
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        stop_test();
    end
endmodule
`default_nettype wire
